// >>> rtl/lfp_top.sv
// Purpose: Protection byte and extended configuration byte with their access decode.
// Assumes: Classic Wishbone slave; one clock; synchronous active-high reset.
// Notes: The programming side reaches the bytes through the bus, the core side
//        through the permission ports.
`timescale 1ns/10ps
`include "lfp_regs.svh"
module lfp_top #(
	parameter int PC_W = 15,
	parameter int ADR_W = 8
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// External programming requests.
	input wire logic ext_write_req_i,
	input wire logic ext_verify_req_i,
	output logic ext_write_allow_o,
	output logic ext_verify_allow_o,
	// Self-programming side.
	input wire logic [PC_W-1:0] boot_start_i,
	input wire logic [PC_W-1:0] pc_i,
	input wire logic [PC_W-1:0] store_addr_i,
	input wire logic [PC_W-1:0] read_addr_i,
	input wire logic vectors_in_boot_i,
	output logic self_program_store_allow_o,
	output logic program_memory_read_allow_o,
	output logic irq_allow_o,
	// Configuration outputs.
	output logic prog_mode_o,
	output logic output_stage_forced_o,
	output logic output_a_high_o,
	output logic output_b_high_o,
	output logic [2:0] brownout_level_o,
	output logic eeprom_preserve_bit_o,
	output logic flash_erase_o,
	output logic eeprom_erase_o
);

	////////////////////////////////////////////////////////////////////////////
	// Bus decode.

	logic ack_reg;
	logic access;
	logic wr;
	logic wr_lane;
	logic hit_prot;
	logic hit_xcfg;
	logic hit_ctrl;
	logic hit_stat;

	// One access per request; ack drops the cycle after it was given.
	assign access = cyc_i && stb_i && !ack_reg;
	assign wr = access && we_i;
	assign wr_lane = wr && sel_i[0];
	assign hit_prot = (adr_i[ADR_W-1:0] == ADR_W'(`LFP_OFS_PROT));
	assign hit_xcfg = (adr_i[ADR_W-1:0] == ADR_W'(`LFP_OFS_XCFG));
	assign hit_ctrl = (adr_i[ADR_W-1:0] == ADR_W'(`LFP_OFS_CTRL));
	assign hit_stat = (adr_i[ADR_W-1:0] == ADR_W'(`LFP_OFS_STAT));

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_reg <= 1'b0;
		else
			ack_reg <= access;
	end

	assign ack_o = ack_reg;

	////////////////////////////////////////////////////////////////////////////
	// Programming-mode sequencer.

	lfp_pkg::lfp_pm_state_t pm_reg;
	lfp_pkg::lfp_pm_state_t pm_next;
	logic ctrl_wr;

	assign ctrl_wr = wr_lane && hit_ctrl;

	always_comb
	begin
		pm_next = pm_reg;
		case (pm_reg)
			lfp_pkg::PM_NORMAL:
			begin
				if (ctrl_wr && dat_i[`LFP_CTRL_PROG])
					pm_next = lfp_pkg::PM_PROG;
			end
			lfp_pkg::PM_PROG:
			begin
				if (ctrl_wr && !dat_i[`LFP_CTRL_PROG])
					pm_next = lfp_pkg::PM_NORMAL;
				else if (ctrl_wr && dat_i[`LFP_CTRL_ERASE])
					pm_next = lfp_pkg::PM_ERASE;
			end
			lfp_pkg::PM_ERASE:
				pm_next = lfp_pkg::PM_PROG;
			default:
				pm_next = lfp_pkg::PM_NORMAL;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pm_reg <= lfp_pkg::PM_NORMAL;
		else
			pm_reg <= pm_next;
	end

	logic in_prog;
	logic erase_now;

	assign in_prog = (pm_reg == lfp_pkg::PM_PROG);
	assign erase_now = (pm_reg == lfp_pkg::PM_ERASE);
	assign prog_mode_o = (pm_reg != lfp_pkg::PM_NORMAL);

	////////////////////////////////////////////////////////////////////////////
	// Nonvolatile bytes.

	lfp_pkg::lfp_byte_t prot_val;
	lfp_pkg::lfp_byte_t xcfg_val;
	lfp_pkg::lfp_byte_t prot_mask;
	lfp_pkg::lfp_byte_t xcfg_mask;
	logic prot_prog;
	logic xcfg_prog;
	logic glb_lo_set;
	logic glb_all_set;

	assign glb_lo_set = !prot_val[`LFP_GLB_LO];
	assign glb_all_set = !prot_val[`LFP_GLB_LO] && !prot_val[`LFP_GLB_HI];

	// Global bits may always be programmed further; section bits freeze with both.
	assign prot_mask = glb_all_set ? `LFP_PROT_GLB : (`LFP_PROT_GLB | `LFP_PROT_SECT);
	// Configuration freezes as soon as the low global bit is programmed.
	assign xcfg_mask = glb_lo_set ? 8'h00 : ~`LFP_XCFG_UNUSED;
	assign prot_prog = in_prog && wr_lane && hit_prot;
	assign xcfg_prog = in_prog && wr_lane && hit_xcfg;

	// Programming can only clear bits; erase alone sets them again.
	lfp_nvm_byte #(
		.DEFAULT(`LFP_PROT_RST),
		.FIXED(`LFP_PROT_UNUSED)
	) u_prot (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.prog_i(prot_prog),
		.prog_mask_i(prot_mask),
		.prog_data_i(dat_i[7:0]),
		.erase_i(erase_now),
		.value_o(prot_val)
	);

	// Erase leaves the configuration byte alone.
	lfp_nvm_byte #(
		.DEFAULT(`LFP_XCFG_RST),
		.FIXED(`LFP_XCFG_UNUSED)
	) u_xcfg (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.prog_i(xcfg_prog),
		.prog_mask_i(xcfg_mask),
		.prog_data_i(dat_i[7:0]),
		.erase_i(1'b0),
		.value_o(xcfg_val)
	);

	////////////////////////////////////////////////////////////////////////////
	// Configuration latch.

	lfp_pkg::lfp_byte_t xcfg_latched_reg;
	logic power_up_reg;
	logic pm_edge;

	// Entry and exit both reload; while programming the old value stays in force.
	assign pm_edge = (pm_reg == lfp_pkg::PM_NORMAL) != (pm_next == lfp_pkg::PM_NORMAL);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			power_up_reg <= 1'b1;
		else
			power_up_reg <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			xcfg_latched_reg <= `LFP_XCFG_RST;
		else if (power_up_reg || pm_edge)
			xcfg_latched_reg <= xcfg_val;
	end

	// A programmed select bit forces the stage; a programmed level bit means high.
	assign output_stage_forced_o = !xcfg_latched_reg[`LFP_XCFG_SEL];
	assign output_a_high_o = !xcfg_latched_reg[`LFP_XCFG_LVL_A];
	assign output_b_high_o = !xcfg_latched_reg[`LFP_XCFG_LVL_B];
	assign brownout_level_o = xcfg_latched_reg[`LFP_XCFG_BRN_MSB:`LFP_XCFG_BRN_LSB];

	////////////////////////////////////////////////////////////////////////////
	// Control register and erase strobes.

	logic eeprom_preserve_bit_reg;
	logic eeprom_preserve_bit_next;
	logic flash_erase_reg;
	logic eeprom_erase_reg;

	// The preserve bit bypasses the latch and acts at once, even on the write that erases.
	assign eeprom_preserve_bit_next = ctrl_wr ? dat_i[`LFP_CTRL_EEPROM_PRESERVE_BIT] : eeprom_preserve_bit_reg;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			eeprom_preserve_bit_reg <= 1'b0;
		else
			eeprom_preserve_bit_reg <= eeprom_preserve_bit_next;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			flash_erase_reg <= 1'b0;
			eeprom_erase_reg <= 1'b0;
		end
		else
		begin
			flash_erase_reg <= (pm_next == lfp_pkg::PM_ERASE);
			eeprom_erase_reg <= (pm_next == lfp_pkg::PM_ERASE) && !eeprom_preserve_bit_next;
		end
	end

	assign eeprom_preserve_bit_o = eeprom_preserve_bit_reg;
	assign flash_erase_o = flash_erase_reg;
	assign eeprom_erase_o = eeprom_erase_reg;

	////////////////////////////////////////////////////////////////////////////
	// Access decode.

	logic dec_write_ok;
	logic dec_verify_ok;

	lfp_access_decode #(
		.PC_W(PC_W)
	) u_dec (
		.prot_i(prot_val),
		.boot_start_i(boot_start_i),
		.pc_i(pc_i),
		.store_addr_i(store_addr_i),
		.read_addr_i(read_addr_i),
		.vectors_in_boot_i(vectors_in_boot_i),
		.store_allow_o(self_program_store_allow_o),
		.read_allow_o(program_memory_read_allow_o),
		.irq_allow_o(irq_allow_o),
		.ext_write_allow_o(dec_write_ok),
		.ext_verify_allow_o(dec_verify_ok)
	);

	// External access needs programming mode as well as an open lock.
	assign ext_write_allow_o = in_prog && dec_write_ok;
	assign ext_verify_allow_o = in_prog && dec_verify_ok;

	////////////////////////////////////////////////////////////////////////////
	// Refusal flag.

	logic refused_reg;
	logic refuse_event;
	logic frozen_try;

	// A write that tries to program a frozen bit counts as refused.
	assign frozen_try = (prot_prog && |(~dat_i[7:0] & ~prot_mask & ~`LFP_PROT_UNUSED))
		|| (xcfg_prog && |(~dat_i[7:0] & ~xcfg_mask & ~`LFP_XCFG_UNUSED))
		|| (wr_lane && (hit_prot || hit_xcfg) && !in_prog);
	assign refuse_event = frozen_try
		|| (ext_write_req_i && !ext_write_allow_o)
		|| (ext_verify_req_i && !ext_verify_allow_o);

	// Set wins over the write-one clear so no refusal is lost.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			refused_reg <= 1'b0;
		else if (refuse_event)
			refused_reg <= 1'b1;
		else if (wr_lane && hit_stat && dat_i[`LFP_STAT_REFUSED])
			refused_reg <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data.

	logic [31:0] rd_next;
	logic [31:0] dat_reg;

	always_comb
	begin
		rd_next = 32'h0000_0000;
		if (hit_prot)
			rd_next[7:0] = prot_val;
		else if (hit_xcfg)
			rd_next[7:0] = xcfg_val;
		else if (hit_ctrl)
		begin
			rd_next[`LFP_CTRL_PROG] = prog_mode_o;
			rd_next[`LFP_CTRL_EEPROM_PRESERVE_BIT] = eeprom_preserve_bit_reg;
		end
		else if (hit_stat)
		begin
			rd_next[`LFP_STAT_PROG] = prog_mode_o;
			rd_next[`LFP_STAT_REFUSED] = refused_reg;
			rd_next[`LFP_STAT_XCFG_LSB+7:`LFP_STAT_XCFG_LSB] = xcfg_latched_reg;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_reg <= 32'h0000_0000;
		else if (access && !we_i)
			dat_reg <= rd_next;
	end

	assign dat_o = dat_reg;

endmodule : lfp_top

// >>> rtl/lfp_regs.svh
// Purpose: Register offsets, field positions and reset values of the protection block.
// Assumes: Word-aligned registers on a 32-bit bus, data in the low byte, except the latched configuration copy in status bits 15:8.
// Notes: Definitions only.
`ifndef LFP_REGS_SVH
`define LFP_REGS_SVH

// Byte offsets.
`define LFP_OFS_PROT 8'h00
`define LFP_OFS_XCFG 8'h04
`define LFP_OFS_CTRL 8'h08
`define LFP_OFS_STAT 8'h0c

// Protection byte fields.
`define LFP_GLB_LO 0
`define LFP_GLB_HI 1
`define LFP_APP_LO 2
`define LFP_APP_HI 3
`define LFP_BOOT_LO 4
`define LFP_BOOT_HI 5
`define LFP_PROT_RST 8'hff
`define LFP_PROT_UNUSED 8'hc0
`define LFP_PROT_SECT 8'h3c
`define LFP_PROT_GLB 8'h03

// Extended configuration byte fields.
`define LFP_XCFG_BRN_LSB 0
`define LFP_XCFG_BRN_MSB 2
`define LFP_XCFG_LVL_B 3
`define LFP_XCFG_LVL_A 4
`define LFP_XCFG_SEL 5
`define LFP_XCFG_RST 8'hff
`define LFP_XCFG_UNUSED 8'hc0

// Control and status fields.
`define LFP_CTRL_PROG 0
`define LFP_CTRL_ERASE 1
`define LFP_CTRL_EEPROM_PRESERVE_BIT 2
`define LFP_STAT_PROG 0
`define LFP_STAT_REFUSED 1
`define LFP_STAT_XCFG_LSB 8

`endif

// >>> rtl/lfp_pkg.sv
// Purpose: Types shared by the protection block.
// Assumes: Nothing beyond the register header.
// Notes: No constants live here; they are macros in the header.
package lfp_pkg;

	typedef logic [7:0] lfp_byte_t;

	typedef enum logic [1:0] {PM_NORMAL, PM_PROG, PM_ERASE} lfp_pm_state_t;

endpackage : lfp_pkg

// >>> rtl/lfp_nvm_byte.sv
// Purpose: One nonvolatile byte whose bits can only be programmed to 0 or erased to 1.
// Assumes: Program and erase are one-cycle strobes.
// Notes: Reset stands in for the factory default of the cells.
`timescale 1ns/10ps
module lfp_nvm_byte #(
	parameter logic [7:0] DEFAULT = 8'hff,
	parameter logic [7:0] FIXED = 8'h00
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Programming strobes.
	input wire logic prog_i,
	input wire logic [7:0] prog_mask_i,
	input wire logic [7:0] prog_data_i,
	input wire logic erase_i,
	// Stored value.
	output logic [7:0] value_o
);

	logic [7:0] cell_reg;
	logic [7:0] cell_next;

	always_comb
	begin
		cell_next = cell_reg;
		if (erase_i)
			cell_next = DEFAULT;
		else if (prog_i)
			cell_next = cell_reg & ~(prog_mask_i & ~prog_data_i & ~FIXED);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cell_reg <= DEFAULT;
		else
			cell_reg <= cell_next;
	end

	assign value_o = cell_reg | FIXED;

endmodule : lfp_nvm_byte

// >>> rtl/lfp_access_decode.sv
// Purpose: Turns the protection byte into access permissions.
// Assumes: Addresses at or above the boot start lie in the boot-loader section.
// Notes: Purely combinational, so every check sees the current restriction.
`timescale 1ns/10ps
`include "lfp_regs.svh"
module lfp_access_decode #(
	parameter int PC_W = 15
) (
	// Protection state.
	input wire logic [7:0] prot_i,
	input wire logic [PC_W-1:0] boot_start_i,
	// Core side.
	input wire logic [PC_W-1:0] pc_i,
	input wire logic [PC_W-1:0] store_addr_i,
	input wire logic [PC_W-1:0] read_addr_i,
	input wire logic vectors_in_boot_i,
	// Permissions.
	output logic store_allow_o,
	output logic read_allow_o,
	output logic irq_allow_o,
	output logic ext_write_allow_o,
	output logic ext_verify_allow_o
);

	function automatic logic in_boot(input logic [PC_W-1:0] a, input logic [PC_W-1:0] s);
		in_boot = (a >= s);
	endfunction : in_boot

	logic pc_boot;

	assign pc_boot = in_boot(pc_i, boot_start_i);

	// A store passes only while the target section's low guard bit is unprogrammed.
	assign store_allow_o = in_boot(store_addr_i, boot_start_i) ?
		prot_i[`LFP_BOOT_LO] : prot_i[`LFP_APP_LO];

	// Reads of the own section always pass; cross-section reads need the high bit.
	always_comb
	begin
		if (in_boot(read_addr_i, boot_start_i))
			read_allow_o = pc_boot | prot_i[`LFP_BOOT_HI];
		else
			read_allow_o = !pc_boot | prot_i[`LFP_APP_HI];
	end

	always_comb
	begin
		irq_allow_o = 1'b1;
		if (!prot_i[`LFP_APP_HI] && vectors_in_boot_i && !pc_boot)
			irq_allow_o = 1'b0;
		if (!prot_i[`LFP_BOOT_HI] && !vectors_in_boot_i && pc_boot)
			irq_allow_o = 1'b0;
	end

	assign ext_write_allow_o = &prot_i[`LFP_GLB_HI:`LFP_GLB_LO];
	assign ext_verify_allow_o = |prot_i[`LFP_GLB_HI:`LFP_GLB_LO];

endmodule : lfp_access_decode

// >>> bench/lfp_core_model.sv
// Purpose: Core-side partner that drives program counter and access targets.
// Assumes: The bench raises step_i for each new access pattern.
// Notes: Corner patterns straddle the boot boundary, where decode slips hide.
`timescale 1ns/10ps
module lfp_core_model (
	// Clock.
	input wire logic clk_i,
	// Bench control.
	input wire logic step_i,
	input wire logic corner_i,
	// Core-side drive.
	output logic [14:0] boot_start_o,
	output logic [14:0] pc_o,
	output logic [14:0] store_addr_o,
	output logic [14:0] read_addr_o,
	output logic vectors_in_boot_o
);
	localparam logic [14:0] STARTS [4] = '{15'h7000, 15'h7800, 15'h7c00, 15'h7e00};
	int seed = 89;
	logic [14:0] bs;
	initial
	begin
		boot_start_o = 15'h7000;
		pc_o = 15'h0000;
		store_addr_o = 15'h0000;
		read_addr_o = 15'h0000;
		vectors_in_boot_o = 1'b0;
	end
	always @(posedge clk_i)
	begin
		if (step_i)
		begin
			bs = STARTS[2'($random(seed))];
			boot_start_o <= bs;
			pc_o <= corner_i ? bs - 15'h0001 : 15'($random(seed));
			store_addr_o <= corner_i ? bs : 15'($random(seed));
			read_addr_o <= corner_i ? bs : 15'($random(seed));
			vectors_in_boot_o <= 1'($random(seed));
		end
	end
endmodule : lfp_core_model

// >>> bench/lfp_asserts.sv
// Purpose: Port-level checks of the protection block.
// Assumes: One clock domain; the stored bytes are not visible here.
// Notes: Relations tie permissions and latched outputs to their causes.
`timescale 1ns/10ps
module lfp_top_checker #(
	parameter int PC_W = 15
) (
	// Clock, reset and bus.
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	// Permissions.
	input wire logic ext_write_allow_o,
	input wire logic ext_verify_allow_o,
	input wire logic [PC_W-1:0] boot_start_i,
	input wire logic [PC_W-1:0] pc_i,
	input wire logic [PC_W-1:0] read_addr_i,
	input wire logic vectors_in_boot_i,
	input wire logic program_memory_read_allow_o,
	input wire logic irq_allow_o,
	// Configuration.
	input wire logic prog_mode_o,
	input wire logic output_stage_forced_o,
	input wire logic output_a_high_o,
	input wire logic output_b_high_o,
	input wire logic [2:0] brownout_level_o,
	input wire logic eeprom_preserve_bit_o,
	input wire logic flash_erase_o,
	input wire logic eeprom_erase_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack missing after request");
	AST_ACK_ONE: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	AST_EXT_CLOSED: assert property (!prog_mode_o |-> !ext_write_allow_o && !ext_verify_allow_o)
		else $error("external access open outside programming");
	AST_EXT_ORDER: assert property (ext_write_allow_o |-> ext_verify_allow_o)
		else $error("write allowed while verify refused");
	AST_OWN_READ: assert property (((pc_i >= boot_start_i) == (read_addr_i >= boot_start_i))
		|-> program_memory_read_allow_o)
		else $error("own-section read refused");
	AST_IRQ_SAME: assert property (((pc_i >= boot_start_i) == vectors_in_boot_i) |-> irq_allow_o)
		else $error("interrupts suppressed with vectors in own section");
	AST_LATCH_HOLD: assert property ((prog_mode_o == $past(prog_mode_o)) |-> $stable({
		output_stage_forced_o, output_a_high_o, output_b_high_o, brownout_level_o}))
		else $error("configuration outputs changed without a mode change");
	AST_ERASE_PULSE: assert property (flash_erase_o |-> prog_mode_o && ack_o ##1 !flash_erase_o)
		else $error("erase pulse malformed");
	AST_EE_ONLY: assert property (eeprom_erase_o |-> flash_erase_o)
		else $error("eeprom erase without chip erase");
	AST_EE_KEEP: assert property (flash_erase_o |-> eeprom_erase_o == !eeprom_preserve_bit_o)
		else $error("eeprom erase ignores preserve bit");
endmodule : lfp_top_checker

bind lfp_top lfp_top_checker #(.PC_W(PC_W)) u_lfp_chk (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .ext_write_allow_o(ext_write_allow_o),
	.ext_verify_allow_o(ext_verify_allow_o), .boot_start_i(boot_start_i), .pc_i(pc_i),
	.read_addr_i(read_addr_i), .vectors_in_boot_i(vectors_in_boot_i),
	.program_memory_read_allow_o(program_memory_read_allow_o), .irq_allow_o(irq_allow_o),
	.prog_mode_o(prog_mode_o), .output_stage_forced_o(output_stage_forced_o),
	.output_a_high_o(output_a_high_o), .output_b_high_o(output_b_high_o),
	.brownout_level_o(brownout_level_o), .eeprom_preserve_bit_o(eeprom_preserve_bit_o),
	.flash_erase_o(flash_erase_o), .eeprom_erase_o(eeprom_erase_o));

// >>> bench/tb.sv
// Purpose: Self-checking bench of the protection block.
// Assumes: Wishbone ack follows one cycle after the request is taken.
// Notes: Every section code pair is programmed; core patterns are random.
`timescale 1ns/10ps
`include "lfp_regs.svh"
module tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
	logic [7:0] adr_i = 8'h00, p;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h00000000, dat_o, q;
	logic ext_write_req_i = 1'b0, ext_verify_req_i = 1'b0, ext_write_allow_o, ext_verify_allow_o;
	logic [14:0] boot_start_i, pc_i, store_addr_i, read_addr_i;
	logic vectors_in_boot_i, self_program_store_allow_o, program_memory_read_allow_o, irq_allow_o;
	logic prog_mode_o, output_stage_forced_o, output_a_high_o, output_b_high_o;
	logic eeprom_preserve_bit_o, flash_erase_o, eeprom_erase_o;
	logic [2:0] brownout_level_o;
	logic [1:0] ers;
	logic step = 1'b0, corner = 1'b0;
	int mismatches = 0, check_count = 0;
	always #25 clk_i = ~clk_i;
	lfp_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.ext_write_req_i(ext_write_req_i), .ext_verify_req_i(ext_verify_req_i),
		.ext_write_allow_o(ext_write_allow_o), .ext_verify_allow_o(ext_verify_allow_o),
		.boot_start_i(boot_start_i), .pc_i(pc_i), .store_addr_i(store_addr_i),
		.read_addr_i(read_addr_i), .vectors_in_boot_i(vectors_in_boot_i),
		.self_program_store_allow_o(self_program_store_allow_o),
		.program_memory_read_allow_o(program_memory_read_allow_o), .irq_allow_o(irq_allow_o),
		.prog_mode_o(prog_mode_o), .output_stage_forced_o(output_stage_forced_o),
		.output_a_high_o(output_a_high_o), .output_b_high_o(output_b_high_o),
		.brownout_level_o(brownout_level_o), .eeprom_preserve_bit_o(eeprom_preserve_bit_o),
		.flash_erase_o(flash_erase_o), .eeprom_erase_o(eeprom_erase_o));
	lfp_core_model u_core (.clk_i(clk_i), .step_i(step), .corner_i(corner),
		.boot_start_o(boot_start_i), .pc_o(pc_i), .store_addr_o(store_addr_i),
		.read_addr_o(read_addr_i), .vectors_in_boot_o(vectors_in_boot_i));
	////////////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		if (mismatches == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Erase strobes are captured in the ack cycle, the only cycle they stand.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'hf;
		dat_i <= d;
		do
		begin
			@(posedge clk_i);
		end
		while (ack_o !== 1'b1);
		chk("ack", 1'b1, ack_o);
		q = dat_o;
		ers = {flash_erase_o, eeprom_erase_o};
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(1'b0, a, 32'h00000000);
		chk(nm, e, q);
	endtask : rd
	function automatic logic [4:0] exp_perm(input logic [7:0] pr, input logic [14:0] bs,
		input logic [14:0] pc, input logic [14:0] sa, input logic [14:0] ra, input logic vib);
		logic pcb;
		logic rab;
		pcb = pc >= bs;
		rab = ra >= bs;
		return {(sa >= bs) ? pr[4] : pr[2], (pcb == rab) | (rab ? pr[5] : pr[3]),
			pcb ? (vib | pr[5]) : (!vib | pr[3]), 2'b00};
	endfunction : exp_perm
	////////////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5000) @(posedge clk_i);
		mismatches++;
		print_verdict;
	end
	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`LFP_OFS_PROT, 32'h000000ff, "prot reset");
		rd(`LFP_OFS_XCFG, 32'h000000ff, "xcfg reset");
		rd(`LFP_OFS_STAT, 32'h0000ff00, "stat reset");
		rd(8'h10, 32'h00000000, "unmapped");
		chk("cfg out reset", 6'h07, {output_stage_forced_o, output_a_high_o, output_b_high_o,
			brownout_level_o});
		wb(1'b1, `LFP_OFS_PROT, 32'h00000000);
		rd(`LFP_OFS_PROT, 32'h000000ff, "prot outside prog");
		rd(`LFP_OFS_STAT, 32'h0000ff02, "refused set");
		wb(1'b1, `LFP_OFS_STAT, 32'h00000002);
		rd(`LFP_OFS_STAT, 32'h0000ff00, "refused clear");
		ext_write_req_i <= 1'b1;
		@(posedge clk_i);
		ext_write_req_i <= 1'b0;
		rd(`LFP_OFS_STAT, 32'h0000ff02, "ext write refused");
		wb(1'b1, `LFP_OFS_STAT, 32'h00000002);
		rd(`LFP_OFS_STAT, 32'h0000ff00, "refused clear again");
		wb(1'b1, `LFP_OFS_CTRL, 32'h00000001);
		chk("ext open", 2'b11, {ext_write_allow_o, ext_verify_allow_o});
		wb(1'b1, `LFP_OFS_XCFG, 32'h000000d2);
		rd(`LFP_OFS_XCFG, 32'h000000d2, "xcfg programmed");
		chk("cfg held", 6'h07, {output_stage_forced_o, output_a_high_o, output_b_high_o,
			brownout_level_o});
		wb(1'b1, `LFP_OFS_CTRL, 32'h00000000);
		chk("cfg applied", 6'h2a, {output_stage_forced_o, output_a_high_o, output_b_high_o,
			brownout_level_o});
		for (int i = 0; i < 16; i++)
		begin
			p = {2'b11, 4'(i), 2'b11};
			wb(1'b1, `LFP_OFS_CTRL, 32'h00000001);
			wb(1'b1, `LFP_OFS_CTRL, (i == 5) ? 32'h00000007 : 32'h00000003);
			chk("erase pulses", (i == 5) ? 2'b10 : 2'b11, ers);
			wb(1'b1, `LFP_OFS_PROT, {24'h000000, p});
			wb(1'b1, `LFP_OFS_CTRL, 32'h00000000);
			rd(`LFP_OFS_PROT, {24'h000000, p}, "prot code");
			step <= 1'b1;
			for (int k = 0; k < 8; k++)
			begin
				corner <= (k == 0);
				@(posedge clk_i);
				if (k > 0)
					chk("perm", exp_perm(p, boot_start_i, pc_i, store_addr_i, read_addr_i,
						vectors_in_boot_i), {self_program_store_allow_o,
						program_memory_read_allow_o, irq_allow_o, ext_write_allow_o,
						ext_verify_allow_o});
			end
			step <= 1'b0;
		end
		wb(1'b1, `LFP_OFS_CTRL, 32'h00000001);
		wb(1'b1, `LFP_OFS_PROT, 32'h000000fe);
		chk("ext low lock", 2'b01, {ext_write_allow_o, ext_verify_allow_o});
		wb(1'b1, `LFP_OFS_XCFG, 32'h00000000);
		rd(`LFP_OFS_XCFG, 32'h000000d2, "xcfg frozen");
		wb(1'b1, `LFP_OFS_PROT, 32'h000000fc);
		chk("ext full lock", 2'b00, {ext_write_allow_o, ext_verify_allow_o});
		wb(1'b1, `LFP_OFS_PROT, 32'h000000f0);
		rd(`LFP_OFS_PROT, 32'h000000fc, "section frozen");
		wb(1'b1, `LFP_OFS_CTRL, 32'h00000003);
		rd(`LFP_OFS_PROT, 32'h000000ff, "erase restores");
		wb(1'b1, `LFP_OFS_CTRL, 32'h00000000);
		rd(`LFP_OFS_STAT, 32'h0000d202, "frozen writes refused");
		print_verdict;
	end
endmodule : tb
